// ### rtl/rxfs_defs.vh
/*
 Constants of the receive framing and network output block: sync word,
 frame lengths, codec selection, UDP framing and timing.
 Assumes inclusion by bare name from the design files of this block only.
*/
`ifndef RXFS_DEFS_VH
`define RXFS_DEFS_VH

`define RXFS_SYNC_WORD        32'h5a0fbe66
`define RXFS_SYNC_DIBITS      13'h0010
`define RXFS_CONV_DIBITS      13'h0400
`define RXFS_TURBO_DIBITS     13'h0200
`define RXFS_CONV_G0          7'h79
`define RXFS_CONV_G1          7'h5b
`define RXFS_CODEC_NONE       2'h0
`define RXFS_CODEC_CONV       2'h1
`define RXFS_CODEC_TURBO      2'h2
`define RXFS_STATUS_CODEC_BIT 2
`define RXFS_STATUS_RESET     8'h00
`define RXFS_TCP_PORT         16'h0400
`define RXFS_UDP_MAX_PAYLOAD  12'h400
`define RXFS_UDP_HDR_LAST     4'hf
`define RXFS_RING_AW          11
`define RXFS_RING_DEPTH       12'h800
`define RXFS_MCLK_PERIOD_NS   4
`define RXFS_UDP_TIMEOUT_NS   500000000
`define RXFS_UDP_TIMEOUT_CYC  (`RXFS_UDP_TIMEOUT_NS / `RXFS_MCLK_PERIOD_NS)

`endif

// ### rtl/rxfs_sync_det.v
/*
 One sync word detector for a single assumed carrier phase rotation.
 Assumes one dibit (bit 1 = I, bit 0 = Q) per valid cycle, MSB-first sync.
*/
`include "rxfs_defs.vh"

module rxfs_sync_det #(
	parameter [1:0] ROT = 2'h0
) (
	input  wire       mclk,
	input  wire       rst_b,
	input  wire       ce,
	input  wire [1:0] dibit,
	input  wire       dibit_valid,
	output reg  [1:0] rot_dibit,
	output wire       hit
);
	reg  [31:0] shift;
	wire [31:0] next_shift;

	always @*
	begin
		case (ROT)
			2'h0: rot_dibit = dibit;
			2'h1: rot_dibit = {dibit[0], ~dibit[1]};
			2'h2: rot_dibit = ~dibit;
			2'h3: rot_dibit = {~dibit[0], dibit[1]};
			default: rot_dibit = dibit;
		endcase
	end

	assign next_shift = {shift[29:0], rot_dibit};
	assign hit = dibit_valid && (next_shift == `RXFS_SYNC_WORD);

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			shift <= 32'h00000000;
		else if (ce && dibit_valid)
			shift <= next_shift;
	end
endmodule // rxfs_sync_det

// ### rtl/rxfs_top.v
/*
 Frame sync insertion and detection with phase ambiguity removal, codec
 frame lengths, codec status, and byte forwarding to a TCP stream or UDP frames.
 Assumes one clock, a TCP/UDP stack downstream and FEC decoding outside.
*/
`include "rxfs_defs.vh"

module rxfs_top #(
	parameter TIMEOUT_CYC = `RXFS_UDP_TIMEOUT_CYC
) (
	input  wire        mclk,
	input  wire        rst_b,
	input  wire        ce,
	input  wire [1:0]  codec_sel,
	input  wire [1:0]  turbo_frames_sel,
	input  wire        tx_strobe,
	input  wire [1:0]  tx_bits,
	output wire        tx_bits_ready,
	output reg  [1:0]  tx_dibit,
	output reg         tx_dibit_valid,
	input  wire [1:0]  rx_dibit,
	input  wire        rx_dibit_valid,
	output reg         rx_locked,
	output reg  [1:0]  rx_phase,
	output reg  [7:0]  codec_status_register,
	input  wire        out_udp_mode,
	input  wire        tcp_connected,
	output wire [15:0] tcp_listen_port,
	output reg  [7:0]  tcp_data,
	output reg         tcp_valid,
	input  wire [31:0] udp_dest_ip,
	output reg  [31:0] udp_dst_ip_out,
	output reg  [7:0]  udp_data,
	output reg         udp_valid,
	output reg         udp_last,
	input  wire        udp_ready,
	output reg         udp_overflow
);
	localparam [1:0] RX_HUNT = 2'h0;
	localparam [1:0] RX_LOCK = 2'h1;
	localparam [1:0] UO_IDLE = 2'h0;
	localparam [1:0] UO_HDR  = 2'h1;
	localparam [1:0] UO_PAY  = 2'h2;
	localparam [31:0] TO_LAST_W = TIMEOUT_CYC - 1;
	localparam [26:0] TO_LAST = TO_LAST_W[26:0];

	wire        turbo = (codec_sel == `RXFS_CODEC_TURBO);
	wire [12:0] frame_dibits;
	wire [12:0] frame_end;

	// Payload dibits per frame: fixed for conv/none, 1/2/4/8 turbo blocks
	assign frame_dibits = turbo ? (`RXFS_TURBO_DIBITS << turbo_frames_sel)
		: `RXFS_CONV_DIBITS;
	assign frame_end = frame_dibits + `RXFS_SYNC_DIBITS - 13'h0001;
	assign tcp_listen_port = `RXFS_TCP_PORT;

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
			codec_status_register <= `RXFS_STATUS_RESET;
		else if (ce)
		begin
			codec_status_register <= {4'h0, rx_locked, 1'b0, turbo_frames_sel};
			codec_status_register[`RXFS_STATUS_CODEC_BIT] <= turbo;
		end
	end

	// Transmit framing: sync dibits, then payload, per symbol strobe
	reg  [12:0] tx_pos;
	reg  [5:0]  conv_st;
	wire        tx_in_sync = (tx_pos < `RXFS_SYNC_DIBITS);
	wire [4:0]  sync_sel = {tx_pos[3:0], 1'b0};
	wire [31:0] sync_shifted = `RXFS_SYNC_WORD << sync_sel;
	wire [6:0]  conv_reg = {tx_bits[1], conv_st};

	// The source must present bits on every payload strobe: the stream is continuous
	assign tx_bits_ready = ce && tx_strobe && !tx_in_sync;

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tx_pos <= 13'h0000;
			conv_st <= 6'h00;
			tx_dibit <= 2'h0;
			tx_dibit_valid <= 1'b0;
		end
		else if (ce)
		begin
			tx_dibit_valid <= tx_strobe;
			if (tx_strobe)
			begin
				tx_pos <= (tx_pos == frame_end) ? 13'h0000 : tx_pos + 13'h0001;
				if (tx_in_sync)
					tx_dibit <= sync_shifted[31:30];
				else if (codec_sel == `RXFS_CODEC_CONV)
				begin
					// One info bit in, two coded bits out
					tx_dibit <= {^(conv_reg & `RXFS_CONV_G0), ^(conv_reg & `RXFS_CONV_G1)};
					conv_st <= conv_reg[6:1];
				end
				else
					tx_dibit <= tx_bits;
			end
		end
	end

	// Receive: four rotated detectors, lock to whichever sees the word first
	wire [3:0] hits;
	wire [7:0] rot_dibits;
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : det
			localparam [31:0] ROT_W = g;
			rxfs_sync_det #(
				.ROT(ROT_W[1:0])
			) u_det (
				.mclk       (mclk),
				.rst_b      (rst_b),
				.ce         (ce),
				.dibit      (rx_dibit),
				.dibit_valid(rx_dibit_valid),
				.rot_dibit  (rot_dibits[2*g+1:2*g]),
				.hit        (hits[g])
			);
		end
	endgenerate

	reg  [1:0]  rx_state;
	reg  [12:0] rx_pos;
	reg  [7:0]  byte_sr;
	reg  [1:0]  byte_cnt;
	reg  [7:0]  rx_byte;
	reg         rx_byte_valid;
	wire [1:0]  cur_dibit = rot_dibits[{rx_phase, 1'b0} +: 2];
	wire [1:0]  hit_rot = hits[0] ? 2'h0 : hits[1] ? 2'h1 : hits[2] ? 2'h2 : 2'h3;

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rx_state <= RX_HUNT;
			rx_pos <= 13'h0000;
			rx_locked <= 1'b0;
			rx_phase <= 2'h0;
			byte_sr <= 8'h00;
			byte_cnt <= 2'h0;
			rx_byte <= 8'h00;
			rx_byte_valid <= 1'b0;
		end
		else if (ce)
		begin
			rx_byte_valid <= 1'b0;
			case (rx_state)
				RX_HUNT:
				begin
					if (|hits)
					begin
						rx_state <= RX_LOCK;
						rx_phase <= hit_rot;
						rx_locked <= 1'b1;
						rx_pos <= 13'h0000;
						byte_cnt <= 2'h0;
					end
				end
				RX_LOCK:
				begin
					if (rx_dibit_valid)
					begin
						if (rx_pos < frame_dibits)
						begin
							// Payload: derotated bits, MSB first into bytes
							byte_sr <= {byte_sr[5:0], cur_dibit};
							byte_cnt <= byte_cnt + 2'h1;
							if (byte_cnt == 2'h3)
							begin
								rx_byte <= {byte_sr[5:0], cur_dibit};
								rx_byte_valid <= 1'b1;
							end
						end
						if (rx_pos == frame_end)
						begin
							rx_pos <= 13'h0000;
							byte_cnt <= 2'h0;
							// A missing word at its expected place drops lock
							if (!hits[rx_phase])
							begin
								rx_state <= RX_HUNT;
								rx_locked <= 1'b0;
							end
						end
						else
							rx_pos <= rx_pos + 13'h0001;
					end
				end
				default:
				begin
					rx_state <= RX_HUNT;
					rx_locked <= 1'b0;
				end
			endcase
		end
	end

	// Stream mode: bytes go out only while a client is connected
	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			tcp_data <= 8'h00;
			tcp_valid <= 1'b0;
		end
		else if (ce)
		begin
			tcp_valid <= rx_byte_valid && !out_udp_mode && tcp_connected;
			if (rx_byte_valid)
				tcp_data <= rx_byte;
		end
	end

	// Datagram mode: ring of bytes, so filling continues while a frame drains
	reg  [7:0]  ring [0:`RXFS_RING_DEPTH-1];
	reg  [11:0] wp;
	reg  [11:0] fs;
	reg  [11:0] rp;
	reg  [26:0] timer;
	reg  [1:0]  uo_state;
	reg  [3:0]  hdr_idx;
	reg  [11:0] frame_len;
	reg  [11:0] remain;
	reg  [15:0] frame_cnt;
	reg  [7:0]  hdr_byte;
	wire [11:0] pending = wp - fs;
	wire        ring_full = ((wp - rp) == `RXFS_RING_DEPTH);
	wire        wr_en = ce && rx_byte_valid && out_udp_mode && !ring_full;
	wire        timed_out = (timer >= TO_LAST);
	wire        close = (uo_state == UO_IDLE) && (pending != 12'h000)
		&& ((pending >= `RXFS_UDP_MAX_PAYLOAD) || timed_out);
	wire [11:0] close_len = (pending >= `RXFS_UDP_MAX_PAYLOAD) ? `RXFS_UDP_MAX_PAYLOAD : pending;
	wire        advance = !udp_valid || udp_ready;

	always @(posedge mclk)
	begin
		if (wr_en)
			ring[wp[`RXFS_RING_AW-1:0]] <= rx_byte;
	end

	always @*
	begin
		case (hdr_idx)
			4'h0: hdr_byte = {4'h0, frame_len[11:8]};
			4'h1: hdr_byte = frame_len[7:0];
			4'h2: hdr_byte = frame_cnt[15:8];
			4'h3: hdr_byte = frame_cnt[7:0];
			default: hdr_byte = 8'h00;
		endcase
	end

	always @(posedge mclk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wp <= 12'h000;
			fs <= 12'h000;
			rp <= 12'h000;
			timer <= 27'h0000000;
			uo_state <= UO_IDLE;
			hdr_idx <= 4'h0;
			frame_len <= 12'h000;
			remain <= 12'h000;
			frame_cnt <= 16'h0000;
			udp_dst_ip_out <= 32'h00000000;
			udp_data <= 8'h00;
			udp_valid <= 1'b0;
			udp_last <= 1'b0;
			udp_overflow <= 1'b0;
		end
		else if (ce)
		begin
			udp_overflow <= rx_byte_valid && out_udp_mode && ring_full;
			if (wr_en)
				wp <= wp + 12'h001;
			if (close || pending == 12'h000)
				timer <= 27'h0000000;
			else if (!timed_out)
				timer <= timer + 27'h0000001;
			if (advance)
			begin
				udp_valid <= 1'b0;
				udp_last <= 1'b0;
			end
			case (uo_state)
				UO_IDLE:
				begin
					if (close)
					begin
						frame_len <= close_len;
						remain <= close_len;
						fs <= fs + close_len;
						hdr_idx <= 4'h0;
						udp_dst_ip_out <= udp_dest_ip;
						uo_state <= UO_HDR;
					end
				end
				UO_HDR:
				begin
					if (advance)
					begin
						udp_data <= hdr_byte;
						udp_valid <= 1'b1;
						hdr_idx <= hdr_idx + 4'h1;
						if (hdr_idx == `RXFS_UDP_HDR_LAST)
							uo_state <= UO_PAY;
					end
				end
				UO_PAY:
				begin
					if (advance)
					begin
						udp_data <= ring[rp[`RXFS_RING_AW-1:0]];
						udp_valid <= 1'b1;
						rp <= rp + 12'h001;
						remain <= remain - 12'h001;
						if (remain == 12'h001)
						begin
							udp_last <= 1'b1;
							frame_cnt <= frame_cnt + 16'h0001;
							uo_state <= UO_IDLE;
						end
					end
				end
				default: uo_state <= UO_IDLE;
			endcase
		end
	end
endmodule // rxfs_top

// ### sim/rxfs_checker.sv
/*
 Port assertions for the receive framing block.
 Assumes a bind into rxfs_top, one clock, reset active low.
*/
module rxfs_checker (
	input wire        mclk,
	input wire        rst_b,
	input wire        ce,
	input wire [1:0]  codec_sel,
	input wire        tx_strobe,
	input wire        tx_bits_ready,
	input wire        tx_dibit_valid,
	input wire        rx_dibit_valid,
	input wire        rx_locked,
	input wire [7:0]  codec_status_register,
	input wire        out_udp_mode,
	input wire [15:0] tcp_listen_port,
	input wire        tcp_valid,
	input wire [31:0] udp_dest_ip,
	input wire [31:0] udp_dst_ip_out,
	input wire [7:0]  udp_data,
	input wire        udp_valid,
	input wire        udp_last,
	input wire        udp_ready
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_b);

	a_listen_port: assert property (tcp_listen_port == 16'h0400)
		else $error("listen port");
	a_codec_bit: assert property ($past(rst_b) && $past(ce) |-> codec_status_register[2] == ($past(codec_sel) == 2'h2))
		else $error("codec bit");
	a_status_high: assert property (codec_status_register[7:4] == 4'h0)
		else $error("status high");
	a_tx_pulse: assert property ($past(rst_b) && $past(ce) |-> tx_dibit_valid == $past(tx_strobe))
		else $error("tx valid");
	a_ready_cause: assert property (tx_bits_ready |-> ce && tx_strobe)
		else $error("tx ready");
	a_tcp_mode: assert property (tcp_valid |-> $past(!out_udp_mode))
		else $error("tcp in udp mode");
	a_udp_hold: assert property (udp_valid && !udp_ready |=> udp_valid && $stable(udp_data) && $stable(udp_last))
		else $error("udp hold");
	a_udp_dest: assert property ($rose(udp_valid) && $past(ce, 2) |-> udp_dst_ip_out == $past(udp_dest_ip, 2))
		else $error("udp dest");
	a_lock_cause: assert property ($rose(rx_locked) |-> $past(ce && rx_dibit_valid))
		else $error("lock cause");
	c_lock: cover property ($rose(rx_locked));
	c_tcp: cover property (tcp_valid);
	c_udp_end: cover property (udp_valid && udp_ready && udp_last);
endmodule // rxfs_checker

bind rxfs_top rxfs_checker chk_u (.mclk, .rst_b, .ce, .codec_sel, .tx_strobe, .tx_bits_ready, .tx_dibit_valid,
	.rx_dibit_valid, .rx_locked, .codec_status_register, .out_udp_mode, .tcp_listen_port, .tcp_valid,
	.udp_dest_ip, .udp_dst_ip_out, .udp_data, .udp_valid, .udp_last, .udp_ready);

// ### sim/rxfs_udp_sink.sv
/*
 Remote UDP client model: takes frame bytes, stalling on request.
 Assumes the bench drains q once a frame is in.
*/
module rxfs_udp_sink (
	input wire       mclk,
	input wire       rst_b,
	input wire       slow,
	input wire [7:0] udp_data,
	input wire       udp_valid,
	input wire       udp_last,
	output logic     udp_ready
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [8:0] q[$];

	// With slow set, every other cycle stalled, so a pending byte must be held
	always @(posedge mclk or negedge rst_b)
		if (!rst_b)
			udp_ready <= 1'b0;
		else
		begin
			udp_ready <= slow ? ~udp_ready : 1'b1;
			if (udp_valid && udp_ready)
				q.push_back({udp_last, udp_data});
		end
endmodule // rxfs_udp_sink

// ### sim/rxfs_top_tb.sv
/*
 Self-checking bench: status, transmit framing, lock, TCP and UDP output.
 Assumes the UDP sink model and the bound checker.
*/
module rxfs_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic       mclk, rst_b, ce, tx_strobe, rx_dibit_valid, out_udp_mode, tcp_connected, slow;
	logic [1:0] codec_sel, turbo_frames_sel, tx_bits, rx_dibit, xr;
	logic [7:0] bv, eb;
	logic [31:0] udp_dest_ip;
	wire [31:0] udp_dst_ip_out;
	wire        tx_bits_ready, rx_locked, tcp_valid, udp_valid, udp_last, udp_ready;
	wire [1:0]  tx_dibit, rx_phase;
	wire [7:0]  codec_status_register, tcp_data, udp_data;
	wire [15:0] tcp_listen_port;
	logic [7:0] tq[$];
	int         n_errors, n_checks, pc;

	rxfs_top #(.TIMEOUT_CYC(8000)) dut_u (.mclk, .rst_b, .ce, .codec_sel, .turbo_frames_sel, .tx_strobe,
		.tx_bits, .tx_bits_ready, .tx_dibit, .tx_dibit_valid(), .rx_dibit, .rx_dibit_valid, .rx_locked,
		.rx_phase, .codec_status_register, .out_udp_mode, .tcp_connected, .tcp_listen_port, .tcp_data,
		.tcp_valid, .udp_dest_ip, .udp_dst_ip_out, .udp_data, .udp_valid, .udp_last, .udp_ready,
		.udp_overflow());
	rxfs_udp_sink sink_u (.mclk, .rst_b, .slow, .udp_data, .udp_valid, .udp_last, .udp_ready);

	always @(posedge mclk)
		if (tcp_valid === 1'b1)
			tq.push_back(tcp_data);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic step;
		@(posedge mclk);
		#1;
	endtask

	task automatic rxs(input logic [31:0] w, input int nd);
		for (int i = nd - 1; i >= 0; i--)
		begin
			step;
			rx_dibit = w[2 * i +: 2] ^ xr;
			rx_dibit_valid = 1'b1;
		end
		step;
		rx_dibit_valid = 1'b0;
	endtask

	// Sync after every 256 bytes, or the receiver drops lock
	task automatic rxb;
		rxs(bv, 4);
		bv++;
		pc++;
		if (pc == 256)
		begin
			rxs(32'h5a0fbe66, 16);
			pc = 0;
		end
	endtask

	task automatic wq(input int k);
		for (int i = 0; i < 20000 && sink_u.q.size() < k; i++)
			step;
		if (sink_u.q.size() < k)
		begin
			n_errors++;
			report_and_stop;
		end
	endtask

	task automatic frm(input int n, input logic [15:0] cnt);
		logic [7:0] e;
		for (int i = 0; i < n + 16; i++)
		begin
			e = i == 0 ? n[15:8] : i == 1 ? n[7:0] : i == 2 ? cnt[15:8] : i == 3 ? cnt[7:0] : i < 16 ? 8'h00 : eb;
			if (i >= 16)
				eb++;
			chk(sink_u.q.pop_front(), {i == n + 15, e});
		end
	endtask

	task automatic t_status;
		chk(tcp_listen_port, 16'h0400);
		turbo_frames_sel = 2'h3;
		for (int c = 0; c < 4; c++)
		begin
			codec_sel = c;
			repeat (2) step;
			chk(codec_status_register, {5'h0, c == 2, 2'h3});
		end
		codec_sel = 2'h0;
	endtask

	task automatic txfr(input int p);
		logic [31:0] w;
		int n;
		n = 0;
		tx_strobe = 1'b1;
		for (int i = 0; i < 16; i++)
		begin
			chk(tx_bits_ready, 1'b0);
			step;
			w = {w[29:0], tx_dibit};
		end
		while (tx_bits_ready === 1'b1 && n < 5000)
		begin
			n++;
			step;
		end
		chk(w, 32'h5a0fbe66);
		chk(n, p);
	endtask

	task automatic t_tx;
		txfr(1024);
		codec_sel = 2'h2;
		for (int s = 0; s < 4; s++)
		begin
			turbo_frames_sel = s;
			txfr(512 << s);
		end
		tx_strobe = 1'b0;
		codec_sel = 2'h0;
	endtask

	// From a cleared encoder, input 1 then 0 gives 11 then 10 with the set generators
	task automatic t_conv;
		codec_sel = 2'h1;
		tx_strobe = 1'b1;
		repeat (16) step;
		tx_bits = 2'h2;
		step;
		chk(tx_dibit, 2'h3);
		tx_bits = 2'h0;
		ce = 1'b0;
		repeat (3) step;
		chk(tx_dibit, 2'h3);
		ce = 1'b1;
		step;
		chk(tx_dibit, 2'h2);
		tx_strobe = 1'b0;
		codec_sel = 2'h0;
	endtask

	task automatic t_rx;
		tcp_connected = 1'b1;
		xr = 2'h3;
		rxs(32'hff, 4);
		rxs(32'h5a0fbe66, 16);
		step;
		chk(rx_locked, 1'b1);
		chk(rx_phase, 2'h2);
		bv = 8'ha0;
		repeat (2) rxb;
		repeat (4) step;
		tcp_connected = 1'b0;
		rxb;
		repeat (8) step;
		chk(tq.size(), 2);
		chk(tq[0], 8'ha0);
		chk(tq[1], 8'ha1);
	endtask

	task automatic t_udp;
		out_udp_mode = 1'b1;
		slow = 1'b1;
		bv = 8'h40;
		eb = 8'h40;
		repeat (3) rxb;
		wq(19);
		frm(3, 16'h0);
		chk(udp_dst_ip_out, 32'hc0a80117);
		udp_dest_ip = 32'h0a000005;
		slow = 1'b0;
		repeat (1030) rxb;
		wq(1062);
		frm(1024, 16'h1);
		frm(6, 16'h2);
		chk(udp_dst_ip_out, 32'h0a000005);
	endtask

	initial
	begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	initial
	begin
		{rst_b, tx_strobe, rx_dibit_valid, out_udp_mode, tcp_connected, slow} = 6'h00;
		{codec_sel, turbo_frames_sel, tx_bits, rx_dibit, xr} = 10'h000;
		ce = 1'b1;
		udp_dest_ip = 32'hc0a80117;
		pc = 0;
		repeat (2) @(posedge mclk);
		#1 rst_b = 1'b1;
		t_status;
		t_tx;
		t_conv;
		t_rx;
		t_udp;
		report_and_stop;
	end
endmodule // rxfs_top_tb
